// ==== rtl/lin_ctrl_consts.svh ====
// timing constants of the transceiver mode controller
`ifndef LIN_CTRL_CONSTS_SVH
`define LIN_CTRL_CONSTS_SVH
`define CLK_MHZ 125
`define BUS_WAKE_LOW_NS 70000
`define BUS_WAKE_LOW_CYC ((`BUS_WAKE_LOW_NS * `CLK_MHZ + 999) / 1000)
`define TX_TIMEOUT_US 25000
`define TX_TIMEOUT_CYC (`TX_TIMEOUT_US * `CLK_MHZ)
`define SEL_FILT_NS 10000
`define SEL_FILT_CYC ((`SEL_FILT_NS * `CLK_MHZ + 999) / 1000)
`define SUPPLY_SETTLE_CYC 16
`endif

// ==== rtl/lin_ctrl_pkg.sv ====
// types of the transceiver mode controller
package lin_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_READY = 3'b001,
        ST_OPER = 3'b010,
        ST_TXOFF = 3'b011,
        ST_PDOWN = 3'b100,
        ST_WAKE = 3'b101
    } mode_t;
endpackage

// ==== rtl/lin_filt_if.sv ====
// filtered pin levels passed from the input conditioner to the controller
interface lin_filt_if;
    logic sel;
    logic sel_fall;
    logic wake_fall;
    logic txd;
    logic txd_rise;
    logic bus;
    logic bus_wake;
    modport src (output sel, sel_fall, wake_fall, txd, txd_rise, bus,
        bus_wake);
    modport dst (input sel, sel_fall, wake_fall, txd, txd_rise, bus,
        bus_wake);
endinterface

// ==== rtl/lin_dom_timer.sv ====
// saturating timer that counts while a level is held, clears otherwise
module lin_dom_timer #(
    parameter int LIMIT = 100
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    output logic expired
);
    localparam int W = $clog2(LIMIT + 1);
    logic [W-1:0] cnt_ff;

    initial begin
        if (LIMIT < 1) begin
            $error("timer limit must be positive");
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (!run) begin
            cnt_ff <= '0;
        end else if (cnt_ff != W'(LIMIT)) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    assign expired = (cnt_ff == W'(LIMIT));
endmodule

// ==== rtl/lin_mode_ctrl.sv ====
// mode and fault controller of a single-wire bus transceiver
// What this block does
// - thermal overload from output overload or die heat disables the transmitter
// - thermal fault clears itself once die temperature falls below recovery
// - power-down keeps only wake detection; receiver released, strong pull-up open
// - select high or wake falling edge wakes power-down into ready
// - rising bus edge after at least 70 us low also wakes to ready
// - select held high while waking continues to operation or tx off
// - after power-on select low gives ready, high gives operation or tx off
// - ready enables regulator and receiver, transmitter stays disabled
// - ready holds while select low; select high picks mode by txd
// - regulator enable high in every state except power-down, power-on and wake-up
// - operation goes to power-down on select fall with txd high
// - operation goes to tx off on any fault
// - in operation rxd must read high while bus recessive
// - tx off is entered whenever a fault disables the transmitter
// - tx off: select fall to power-down, txd high and no fault to operation
// - strong pull-up connected only in operation
// - bus dominant while txd low; txd forced high when transmitter disabled
// - txd low about 25 ms releases the bus; txd rising edge re-enables
// - rxd follows the bus only in ready, operation and tx off; released in power-down, power-on and wake-up
// - select is glitch filtered about 10 us
`include "lin_ctrl_consts.svh"
module lin_mode_ctrl
    import lin_ctrl_pkg::*;
#(
    parameter int TX_TIMEOUT_CYC = `TX_TIMEOUT_CYC,
    parameter int BUS_WAKE_CYC = `BUS_WAKE_LOW_CYC,
    parameter int SEL_FILT_CYC = `SEL_FILT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sel_in,
    input wire logic wake_n_in,
    input wire logic txd_in,
    input wire logic bus_line_in,
    input wire logic thermal_hot,
    input wire logic supply_ok,
    output logic bus_line_out,
    output logic bus_line_oe_n,
    output logic rxd_out,
    output logic rxd_oe_n,
    input wire logic rxd_sense,
    output logic regulator_enable,
    output logic strong_bus_pullup,
    output logic receiver_on,
    output logic transmitter_off_state,
    output logic [3:0] fault_flags
);
    lin_filt_if fi();

    mode_t state_ff, nxt_state;
    logic [4:0] settle_ff;
    logic therm_flt_ff, cont_flt_ff, mon_flt_ff, tmo_flt_ff;
    logic tx_enable;
    logic tmo_expired;
    logic any_fault;
    logic rxd_ff, drive_ff;
    logic [1:0] drv_hist_ff;
    logic reg_en_ff, pull_ff, rx_on_ff;

    initial begin
        if (TX_TIMEOUT_CYC < 2 || BUS_WAKE_CYC < 1 || SEL_FILT_CYC < 1) begin
            $error("timing counts too small");
        end
    end

    lin_pin_cond #(
        .BUS_WAKE_CYC(BUS_WAKE_CYC),
        .SEL_FILT_CYC(SEL_FILT_CYC)
    ) u_cond (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sel_in(sel_in),
        .wake_n_in(wake_n_in),
        .txd_in(txd_in),
        .bus_line_in(bus_line_in),
        .fo(fi.src)
    );

    // txd low counted only while transmitter may drive
    lin_dom_timer #(
        .LIMIT(TX_TIMEOUT_CYC)
    ) u_tmo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(!fi.txd && state_ff == ST_OPER),
        .expired(tmo_expired)
    );

    assign any_fault = therm_flt_ff | cont_flt_ff | mon_flt_ff | tmo_flt_ff;
    assign tx_enable = (state_ff == ST_OPER) && !any_fault;

    // thermal flag tracks the sensor: clears on its own when cool
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            therm_flt_ff <= 1'b0;
        end else begin
            therm_flt_ff <= thermal_hot;
        end
    end

    // contention: we release the bus but it reads dominant
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cont_flt_ff <= 1'b0;
        end else if (state_ff == ST_OPER && fi.txd && !drive_ff
                     && drv_hist_ff == 2'b00 && !fi.bus) begin
            cont_flt_ff <= 1'b1;
        end else if (fi.bus) begin
            cont_flt_ff <= 1'b0;
        end
    end

    // rxd must read high while the bus is recessive
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mon_flt_ff <= 1'b0;
        end else if (state_ff == ST_OPER && fi.bus && rxd_ff
                     && !rxd_sense) begin
            mon_flt_ff <= 1'b1;
        end else if (rxd_sense || !fi.bus) begin
            mon_flt_ff <= 1'b0;
        end
    end

    // timeout holds until txd rises or power-down; set wins over clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tmo_flt_ff <= 1'b0;
        end else if (tmo_expired) begin
            tmo_flt_ff <= 1'b1;
        end else if (fi.txd_rise || state_ff == ST_PDOWN) begin
            tmo_flt_ff <= 1'b0;
        end
    end

    // supply settle counter for por and wake-up
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            settle_ff <= '0;
        end else if ((state_ff == ST_POR || state_ff == ST_WAKE)
                     && supply_ok) begin
            if (settle_ff != 5'(`SUPPLY_SETTLE_CYC)) begin
                settle_ff <= settle_ff + 5'h01;
            end
        end else begin
            settle_ff <= '0;
        end
    end

    // bus read-back trails the driver by two sync stages; an own release
    // must not look like contention while the old dominant drains
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drv_hist_ff <= 2'b00;
        end else begin
            drv_hist_ff <= {drv_hist_ff[0], drive_ff};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR: begin
                if (settle_ff == 5'(`SUPPLY_SETTLE_CYC)) begin
                    if (!fi.sel) begin
                        nxt_state = ST_READY;
                    end else if (fi.txd) begin
                        nxt_state = ST_OPER;
                    end else begin
                        nxt_state = ST_TXOFF;
                    end
                end
            end
            ST_PDOWN: begin
                if (fi.sel || fi.wake_fall || fi.bus_wake) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (settle_ff == 5'(`SUPPLY_SETTLE_CYC)) begin
                    nxt_state = ST_READY;
                end
            end
            ST_READY: begin
                if (fi.sel) begin
                    nxt_state = fi.txd ? ST_OPER : ST_TXOFF;
                end
            end
            ST_OPER: begin
                if (fi.sel_fall && fi.txd) begin
                    nxt_state = ST_PDOWN;
                end else if (any_fault || tmo_expired) begin
                    nxt_state = ST_TXOFF;
                end
            end
            ST_TXOFF: begin
                if (fi.sel_fall) begin
                    nxt_state = ST_PDOWN;
                end else if (fi.sel && fi.txd && !any_fault
                             && !tmo_expired) begin
                    nxt_state = ST_OPER;
                end
            end
            default: begin
                nxt_state = ST_POR;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // mode-dependent supplies and pull-up
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_en_ff <= 1'b0;
            pull_ff <= 1'b0;
            rx_on_ff <= 1'b0;
        end else begin
            reg_en_ff <= (nxt_state != ST_PDOWN && nxt_state != ST_POR
                          && nxt_state != ST_WAKE);
            pull_ff <= (nxt_state == ST_OPER);
            rx_on_ff <= (nxt_state == ST_READY || nxt_state == ST_OPER
                         || nxt_state == ST_TXOFF);
        end
    end

    // driver: dominant only while enabled and txd low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= tx_enable && !tmo_expired && !fi.txd;
        end
    end

    // receiver output released outside receiving modes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxd_ff <= 1'b1;
        end else begin
            rxd_ff <= rx_on_ff ? fi.bus : 1'b1;
        end
    end

    assign bus_line_out = 1'b0;
    assign bus_line_oe_n = !drive_ff;
    assign rxd_out = 1'b0;
    assign rxd_oe_n = rxd_ff;
    assign regulator_enable = reg_en_ff;
    assign strong_bus_pullup = pull_ff;
    assign receiver_on = rx_on_ff;
    assign transmitter_off_state = (state_ff == ST_TXOFF);
    assign fault_flags = {tmo_flt_ff, mon_flt_ff, cont_flt_ff, therm_flt_ff};
endmodule

// ==== rtl/lin_pin_cond.sv ====
// pin synchroniser, select filter and wake detectors
`include "lin_ctrl_consts.svh"
module lin_pin_cond #(
    parameter int BUS_WAKE_CYC = `BUS_WAKE_LOW_CYC,
    parameter int SEL_FILT_CYC = `SEL_FILT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sel_in,
    input wire logic wake_n_in,
    input wire logic txd_in,
    input wire logic bus_line_in,
    lin_filt_if.src fo
);
    localparam int FW = $clog2(SEL_FILT_CYC + 1);
    localparam int BW = $clog2(BUS_WAKE_CYC + 1);
    logic [3:0] s1_ff, s2_ff;
    logic sel_ff, wake_d_ff, txd_d_ff, bus_d_ff;
    logic [FW-1:0] fcnt_ff;
    logic [BW-1:0] bcnt_ff;

    // two-stage synchronisers, one per pin
    genvar i;
    for (i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                s1_ff[i] <= (i == 0) ? 1'b0 : 1'b1;
                s2_ff[i] <= (i == 0) ? 1'b0 : 1'b1;
            end else begin
                s1_ff[i] <= (i == 0) ? sel_in : (i == 1) ? wake_n_in :
                    (i == 2) ? txd_in : bus_line_in;
                s2_ff[i] <= s1_ff[i];
            end
        end
    end

    // select accepted only after a steady run of the new level
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fcnt_ff <= '0;
            sel_ff <= 1'b0;
        end else if (s2_ff[0] == sel_ff) begin
            fcnt_ff <= '0;
        end else if (fcnt_ff == FW'(SEL_FILT_CYC - 1)) begin
            fcnt_ff <= '0;
            sel_ff <= s2_ff[0];
        end else begin
            fcnt_ff <= fcnt_ff + FW'(1);
        end
    end

    // bus low time; short dips never arm a wake
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bcnt_ff <= '0;
        end else if (s2_ff[3]) begin
            bcnt_ff <= '0;
        end else if (bcnt_ff != BW'(BUS_WAKE_CYC)) begin
            bcnt_ff <= bcnt_ff + BW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_d_ff <= 1'b1;
            txd_d_ff <= 1'b1;
            bus_d_ff <= 1'b1;
        end else begin
            wake_d_ff <= s2_ff[1];
            txd_d_ff <= s2_ff[2];
            bus_d_ff <= s2_ff[3];
        end
    end

    assign fo.sel = sel_ff;
    assign fo.sel_fall = sel_ff && (fcnt_ff == FW'(SEL_FILT_CYC - 1))
        && !s2_ff[0];
    assign fo.wake_fall = wake_d_ff && !s2_ff[1];
    assign fo.txd = s2_ff[2];
    assign fo.txd_rise = !txd_d_ff && s2_ff[2];
    assign fo.bus = s2_ff[3];
    assign fo.bus_wake = s2_ff[3] && !bus_d_ff
        && (bcnt_ff == BW'(BUS_WAKE_CYC));
endmodule

// ==== bench/lin_mode_ctrl_asserts.sv ====
// concurrent checks on the mode controller ports
module lin_mode_ctrl_asserts #(
    parameter int TX_TIMEOUT_CYC = 200,
    parameter int BUS_WAKE_CYC = 20,
    parameter int SEL_FILT_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic txd_in,
    input wire logic bus_line_in,
    input wire logic thermal_hot,
    input wire logic bus_line_oe_n,
    input wire logic rxd_oe_n,
    input wire logic regulator_enable,
    input wire logic strong_bus_pullup,
    input wire logic receiver_on,
    input wire logic transmitter_off_state,
    input wire logic [3:0] fault_flags
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    int drive_cnt_ff;
    // a counter, not a long repetition, keeps the tools fast
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drive_cnt_ff <= 0;
        end else begin
            drive_cnt_ff <= bus_line_oe_n ? 0 : drive_cnt_ff + 1;
        end
    end
    property p_pdown_quiet;
        !regulator_enable [*2] |-> !strong_bus_pullup && rxd_oe_n &&
            bus_line_oe_n && !receiver_on;
    endproperty
    a_pdown_quiet: assert property (p_pdown_quiet)
        else $error("quiet state still drives");
    property p_pullup_oper;
        strong_bus_pullup |-> regulator_enable && receiver_on;
    endproperty
    a_pullup_oper: assert property (p_pullup_oper)
        else $error("strong pull-up outside operation");
    property p_txoff_quiet;
        transmitter_off_state [*3] |-> bus_line_oe_n && !strong_bus_pullup
            && regulator_enable;
    endproperty
    a_txoff_quiet: assert property (p_txoff_quiet)
        else $error("tx off state not quiet");
    property p_ready_no_tx;
        (receiver_on && !strong_bus_pullup) [*3] |-> bus_line_oe_n;
    endproperty
    a_ready_no_tx: assert property (p_ready_no_tx)
        else $error("bus driven outside operation");
    property p_txd_high;
        txd_in [*6] |-> bus_line_oe_n;
    endproperty
    a_txd_high: assert property (p_txd_high)
        else $error("bus driven with txd high");
    property p_thermal;
        thermal_hot [*6] |-> fault_flags[0];
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("thermal flag missing");
    property p_thermal_exit;
        thermal_hot && strong_bus_pullup |-> ##[1:8] !strong_bus_pullup;
    endproperty
    a_thermal_exit: assert property (p_thermal_exit)
        else $error("operation kept under overload");
    property p_timeout;
        drive_cnt_ff <= TX_TIMEOUT_CYC + 8;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("dominant held past timeout");
    property p_rxd_follow;
        (receiver_on && $stable(bus_line_in)) [*6] |->
            rxd_oe_n == bus_line_in;
    endproperty
    a_rxd_follow: assert property (p_rxd_follow)
        else $error("rxd does not follow bus");
    c_oper: cover property ($rose(strong_bus_pullup));
    c_txoff: cover property ($rose(transmitter_off_state));
    c_pdown: cover property ($fell(regulator_enable));
    c_tmo: cover property (fault_flags[3]);
endmodule
bind lin_mode_ctrl lin_mode_ctrl_asserts #(
    .TX_TIMEOUT_CYC(TX_TIMEOUT_CYC),
    .BUS_WAKE_CYC(BUS_WAKE_CYC),
    .SEL_FILT_CYC(SEL_FILT_CYC)
) u_lin_mode_ctrl_asserts (.clk_sys, .resetn, .txd_in, .bus_line_in,
    .thermal_hot, .bus_line_oe_n, .rxd_oe_n, .regulator_enable,
    .strong_bus_pullup, .receiver_on, .transmitter_off_state, .fault_flags);

// ==== bench/lin_bus_model.sv ====
// bus wire and receive pin with pull-ups, plus a foreign dominant driver
module lin_bus_model (
    input wire logic bus_line_out,
    input wire logic bus_line_oe_n,
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic ext_dom,
    input wire logic rxd_open,
    output logic bus_line,
    output logic rxd_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // released wire sits at the pull-up level, never the last value
    assign bus_line = (!bus_line_oe_n && !bus_line_out) || ext_dom ? 1'b0
        : 1'b1;
    // missing rxd pull-up: a released pin reads low
    assign rxd_pin = !rxd_oe_n ? rxd_out : !rxd_open;
endmodule

// ==== bench/lin_transceiver_mode_control_tb_top.sv ====
// self-checking bench of the transceiver mode controller
module lin_transceiver_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, resetn = 1'b0, sel_in = 1'b0, wake_n_in = 1'b1;
    logic txd_in = 1'b1, thermal_hot = 1'b0, supply_ok = 1'b1;
    logic ext_dom = 1'b0, bus_line, rxd_pin, bus_line_out, bus_line_oe_n;
    logic rxd_out, rxd_oe_n, regulator_enable, strong_bus_pullup;
    logic receiver_on, transmitter_off_state;
    logic rxd_open = 1'b0;
    logic [3:0] fault_flags;
    int bad_count = 0, check_count = 0, n;
    always #4 clk_sys = ~clk_sys;
    lin_mode_ctrl #(.TX_TIMEOUT_CYC(200), .BUS_WAKE_CYC(20),
        .SEL_FILT_CYC(4)) u_lin_mode_ctrl (.clk_sys, .resetn, .sel_in,
        .wake_n_in, .txd_in, .bus_line_in(bus_line), .thermal_hot,
        .supply_ok, .bus_line_out, .bus_line_oe_n, .rxd_out, .rxd_oe_n,
        .rxd_sense(rxd_pin), .regulator_enable, .strong_bus_pullup,
        .receiver_on,
        .transmitter_off_state, .fault_flags);
    lin_bus_model u_lin_bus_model (.bus_line_out, .bus_line_oe_n, .rxd_out,
        .rxd_oe_n, .ext_dom, .rxd_open, .bus_line, .rxd_pin);
    task chk(input string nm, input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task to_oper;
        sel_in = 1'b1;
        txd_in = 1'b1;
        for (n = 0; n < 40 && strong_bus_pullup !== 1'b1; n++) cyc(1);
    endtask
    task to_pdown;
        to_oper();
        sel_in = 1'b0;
        for (n = 0; n < 40 && regulator_enable !== 1'b0; n++) cyc(1);
    endtask
    task t_por;
        cyc(6);
        resetn = 1'b1;
        for (n = 0; n < 100 && regulator_enable !== 1'b1; n++) cyc(1);
        chk("regulator_enable", regulator_enable, 1'b1);
        chk("receiver_on", receiver_on, 1'b1);
        chk("bus_line_oe_n", bus_line_oe_n, 1'b1);
    endtask
    task t_glitch;
        sel_in = 1'b1;
        cyc(2);
        sel_in = 1'b0;
        cyc(20);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b0);
        chk("regulator_enable", regulator_enable, 1'b1);
    endtask
    task t_oper;
        to_oper();
        chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
        txd_in = 1'b0;
        for (n = 0; n < 10 && rxd_pin !== 1'b0; n++) cyc(1);
        chk("bus_line", bus_line, 1'b0);
        chk("rxd_pin", rxd_pin, 1'b0);
        txd_in = 1'b1;
        for (n = 0; n < 8; n++) begin
            cyc(1);
            chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
        end
        chk("rxd_pin", rxd_pin, 1'b1);
    endtask
    task t_contend;
        ext_dom = 1'b1;
        for (n = 0; n < 20 && transmitter_off_state !== 1'b1; n++) cyc(1);
        chk("transmitter_off_state", transmitter_off_state, 1'b1);
        chk("contention flag", fault_flags[1], 1'b1);
        ext_dom = 1'b0;
        for (n = 0; n < 20 && strong_bus_pullup !== 1'b1; n++) cyc(1);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
        chk("contention flag", fault_flags[1], 1'b0);
    endtask
    task t_timeout;
        txd_in = 1'b0;
        cyc(190);
        chk("transmitter_off_state", transmitter_off_state, 1'b0);
        for (n = 0; n < 80 && transmitter_off_state !== 1'b1; n++) cyc(1);
        chk("timeout flag", fault_flags[3], 1'b1);
        cyc(3);
        chk("bus_line", bus_line, 1'b1);
        txd_in = 1'b1;
        for (n = 0; n < 20 && strong_bus_pullup !== 1'b1; n++) cyc(1);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
    endtask
    task t_thermal;
        thermal_hot = 1'b1;
        for (n = 0; n < 20 && transmitter_off_state !== 1'b1; n++) cyc(1);
        chk("thermal flag", fault_flags[0], 1'b1);
        txd_in = 1'b0;
        cyc(6);
        chk("bus_line", bus_line, 1'b1);
        txd_in = 1'b1;
        thermal_hot = 1'b0;
        for (n = 0; n < 20 && strong_bus_pullup !== 1'b1; n++) cyc(1);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
    endtask
    task t_rxd_mon;
        rxd_open = 1'b1;
        for (n = 0; n < 20 && transmitter_off_state !== 1'b1; n++) cyc(1);
        chk("transmitter_off_state", transmitter_off_state, 1'b1);
        chk("monitor flag", fault_flags[2], 1'b1);
        rxd_open = 1'b0;
        for (n = 0; n < 20 && strong_bus_pullup !== 1'b1; n++) cyc(1);
        chk("monitor flag", fault_flags[2], 1'b0);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b1);
    endtask
    task t_pdown;
        sel_in = 1'b0;
        for (n = 0; n < 40 && regulator_enable !== 1'b0; n++) cyc(1);
        chk("regulator_enable", regulator_enable, 1'b0);
        chk("receiver_on", receiver_on, 1'b0);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b0);
        wake_n_in = 1'b0;
        cyc(3);
        wake_n_in = 1'b1;
        for (n = 0; n < 60 && regulator_enable !== 1'b1; n++) cyc(1);
        chk("regulator_enable", regulator_enable, 1'b1);
        chk("strong_bus_pullup", strong_bus_pullup, 1'b0);
    endtask
    task t_bus_wake;
        to_pdown();
        ext_dom = 1'b1;
        cyc(10);
        ext_dom = 1'b0;
        cyc(40);
        chk("regulator_enable", regulator_enable, 1'b0);
        ext_dom = 1'b1;
        cyc(40);
        chk("rxd_pin", rxd_pin, 1'b1);
        ext_dom = 1'b0;
        for (n = 0; n < 60 && regulator_enable !== 1'b1; n++) cyc(1);
        chk("regulator_enable", regulator_enable, 1'b1);
    endtask
    task t_sel_wake;
        to_pdown();
        txd_in = 1'b0;
        sel_in = 1'b1;
        for (n = 0; n < 80 && transmitter_off_state !== 1'b1; n++) cyc(1);
        chk("transmitter_off_state", transmitter_off_state, 1'b1);
        sel_in = 1'b0;
        for (n = 0; n < 40 && regulator_enable !== 1'b0; n++) cyc(1);
        chk("regulator_enable", regulator_enable, 1'b0);
        txd_in = 1'b1;
    endtask
    initial begin
        t_por();
        t_glitch();
        t_oper();
        t_contend();
        t_timeout();
        t_thermal();
        t_rxd_mon();
        t_pdown();
        t_bus_wake();
        t_sel_wake();
        summarize();
    end
    // whole run needs about 500 cycles; the limit of 15000 cycles allows about thirty times that
    initial begin
        #120000;
        bad_count++;
        summarize();
    end
endmodule
